// ==== design/lrotp_cfg.svh ====
/*
 Constants for the lock, reset and user OTP register bank and its link.
 Assumes inclusion by bare name from the design files.
*/
`ifndef LROTP_CFG_SVH
`define LROTP_CFG_SVH
// ==========================================
// Register offsets on the link
`define LROTP_A_REV     8'h05
`define LROTP_A_TEMP    8'h0e
`define LROTP_A_LOCK    8'h10
`define LROTP_A_PROG    8'h11
`define LROTP_A_SHR     4'h2
`define LROTP_A_UF2     4'h3
`define LROTP_UF2_LINK  4'h0
`define LROTP_UF2_PADDR 4'h1
// ==========================================
// Field positions and codes
`define LROTP_B_INIT    7
`define LROTP_B_SUPDIS  3
`define LROTP_B_GO      7
`define LROTP_B_EXLINK  3
`define LROTP_B_EXPADDR 2
`define LROTP_RST_W1    2'h0
`define LROTP_RST_W2    2'h3
`define LROTP_RST_W3    2'h1
`define LROTP_RG_UF2    2'h2
`define LROTP_RG_RSVD   2'h3
`define LROTP_REG_RST   8'h00
`define LROTP_LAST_IDX  4'hf
// ==========================================
// Checksum and host timing
`define LROTP_CRC_POLY  8'h07
`define LROTP_CRC_INIT  8'hff
`define LROTP_WB_CMD    8'h00
`define LROTP_WB_STAT   8'h04
`define LROTP_CLK_NS    50
`define LROTP_T_RESP_NS 100000
`endif

// ==== design/lrotp_pkg.sv ====
/*
 Types shared by both ends of the register link.
 Assumes nothing beyond a SystemVerilog compiler.
*/
package lrotp_pkg;
   // Programming sequencer states
   typedef enum logic [2:0] {
      P_IDLE = 3'h1,
      P_COPY = 3'h2,
      P_DONE = 3'h4
   } lrotp_prog_t;
   // Reset code tracker states
   typedef enum logic [2:0] {
      S_IDLE = 3'h1,
      S_GOT1 = 3'h2,
      S_GOT2 = 3'h4
   } lrotp_seq_t;
   // Host link states
   typedef enum logic [1:0] {
      H_IDLE = 2'h1,
      H_WAIT = 2'h2
   } lrotp_host_t;
endpackage

// ==== design/lrotp_if.sv ====
/*
 Register command link between the bus master and the sensor register bank.
 Assumes one clock shared by both ends.
*/
`timescale 1ns/10ps
interface lrotp_if;
   logic       cmd_valid;  // One-cycle command strobe
   logic       cmd_write;  // High for register write
   logic [7:0] cmd_addr;   // Register offset
   logic [7:0] cmd_wdata;  // Write data
   logic       rsp_valid;  // One-cycle answer strobe
   logic [7:0] rsp_data;   // Register contents in answer
   modport dev  (input cmd_valid, cmd_write, cmd_addr, cmd_wdata,
                 output rsp_valid, rsp_data);
   modport host (output cmd_valid, cmd_write, cmd_addr, cmd_wdata,
                 input rsp_valid, rsp_data);
endinterface

// ==== design/lrotp_crc8.sv ====
/*
 Byte-serial CRC-8 engine used when a region is programmed.
 Assumes clear and enable are never high together.
*/
`timescale 1ns/10ps
`include "lrotp_cfg.svh"
module lrotp_crc8 (
   input  wire logic       ref_clk,
   input  wire logic       nrst,
   input  wire logic       clear,
   input  wire logic       en,
   input  wire logic [7:0] din,
   output logic      [7:0] crc
);
   // ==========================================
   // One byte folded per cycle
   function automatic logic [7:0] step(input logic [7:0] c, input logic [7:0] d);
      logic [7:0] r;
      r = c ^ d;
      for (int i = 0; i < 8; i++) begin
         r = r[7] ? ((r << 1) ^ `LROTP_CRC_POLY) : (r << 1);
      end
      return r;
   endfunction
   // Running value
   always_ff @(posedge ref_clk) begin
      if (!nrst || clear) begin
         crc <= `LROTP_CRC_INIT;
      end else if (en) begin
         crc <= step(crc, din);
      end
   end
endmodule

// ==== design/lrotp_device.sv ====
/*
 Sensor-side register bank: revision, temperature, lock and reset control,
 user OTP programming with mirror registers and nonvolatile copies.
 Assumes commands arrive on the link as one-cycle strobes, one at a time.
*/
`timescale 1ns/10ps
`include "lrotp_cfg.svh"
module lrotp_device #(
   parameter logic [3:0] REV_CODE = 4'h9  // Arbitrary value
) (
   input  wire logic       ref_clk,
   input  wire logic       nrst,
   lrotp_if.dev            link,
   input  wire logic       mode_dsi3,
   input  wire logic       mode_psi5_diag,
   input  wire logic       psi5_init3_exit,
   input  wire logic [7:0] temp_value,
   input  wire logic       temp_valid,
   input  wire logic       check_err_clear,
   output logic            device_reset,
   output logic            p0_filter_final,
   output logic            self_test_inhibit,
   output logic            force_pdcm,
   output logic            supply_error_report_disable,
   output logic            rw_check_error,
   output logic            region_check_error,
   output logic            programming_active,
   output logic      [2:0] region_lock
);
   // ==========================================
   // Storage
   logic [7:0] lock_reg;             // Lock and reset control
   logic [7:0] prog_reg;             // OTP program control
   logic [7:0] temp_reg;             // Die temperature
   logic [7:0] shr_mirror [16];      // Shared mirror of regions 0 and 1
   logic [7:0] uf2_mirror [16];      // Region 2 mirror
   logic [7:0] nv_mem [3][16];       // Nonvolatile region copies
   logic [7:0] nv_crc [3];           // Programmed checksums
   logic [7:0] snap [3];             // Fold of region at lock
   logic [1:0] shr_owner;            // Region last programmed from shared
   logic [7:0] rw_ref;               // Fold captured at init lock
   logic       init_q;               // Init lock one cycle late
   logic       rsp_pend;             // Answer due next cycle
   logic       rsp_wr;               // Pending answer is for a write
   logic [7:0] rsp_addr;             // Pending answer offset
   lrotp_pkg::lrotp_prog_t pst;      // Programming state
   lrotp_pkg::lrotp_seq_t  sst;      // Reset tracker state
   logic [1:0] psel;                 // Region being programmed
   logic       pexl;                 // Exclude link type
   logic       pexp;                 // Exclude physical address
   logic [3:0] pidx;                 // Byte index in copy
   logic [7:0] crc;                  // CRC engine result
   // ==========================================
   // Rotating fold over a byte array
   function automatic logic [7:0] fold(input logic [7:0] a [16], input logic [7:0] s0);
      logic [7:0] s;
      s = s0;
      for (int i = 0; i < 16; i++) begin
         s = {s[6:0], s[7]} ^ a[i];
      end
      return s;
   endfunction
   // ==========================================
   // Command decode
   logic       init_lock;
   logic       access_ok;
   logic       take;
   logic       wr;
   logic       wr_free;
   logic       skip;
   logic [7:0] src;
   logic [7:0] sum_all;
   assign init_lock = lock_reg[`LROTP_B_INIT];
   assign access_ok = mode_dsi3 | mode_psi5_diag;
   assign take      = link.cmd_valid;
   assign wr        = take & link.cmd_write & access_ok;
   assign wr_free   = wr & ~init_lock;
   assign src       = (psel == `LROTP_RG_UF2) ? uf2_mirror[pidx] : shr_mirror[pidx];
   assign skip      = (psel == `LROTP_RG_UF2) &&
                      ((pidx == `LROTP_UF2_LINK && pexl) ||
                       (pidx == `LROTP_UF2_PADDR && pexp));
   // Reset bits stay out of the check so reset codes do not trip it
   assign sum_all   = fold(uf2_mirror, fold(shr_mirror, prog_reg ^ {lock_reg[7:2], 2'h0}));
   // ==========================================
   // Lock and reset control register
   always_ff @(posedge ref_clk) begin
      if (!nrst || device_reset) begin
         lock_reg <= `LROTP_REG_RST;
      end else begin
         if (wr && link.cmd_addr == `LROTP_A_LOCK) begin
            if (init_lock) begin
               lock_reg[1:0] <= link.cmd_wdata[1:0];
            end else begin
               lock_reg <= link.cmd_wdata;
            end
         end
         if (psi5_init3_exit) begin
            lock_reg[`LROTP_B_INIT] <= 1'b1;
         end else if (init_lock) begin
            lock_reg[`LROTP_B_INIT] <= 1'b1;
         end
      end
   end
   // ==========================================
   // Temperature capture, zero until first sample
   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         temp_reg <= `LROTP_REG_RST;
      end else if (temp_valid) begin
         temp_reg <= temp_value;
      end
   end
   // ==========================================
   // Reset code tracker
   always_ff @(posedge ref_clk) begin
      if (!nrst || device_reset) begin
         sst          <= lrotp_pkg::S_IDLE;
         device_reset <= 1'b0;
      end else begin
         device_reset <= 1'b0;
         if (take) begin
            if (wr && link.cmd_addr == `LROTP_A_LOCK &&
                sst == lrotp_pkg::S_GOT2 && link.cmd_wdata[1:0] == `LROTP_RST_W3) begin
               device_reset <= 1'b1;
               sst          <= lrotp_pkg::S_IDLE;
            end else if (wr && link.cmd_addr == `LROTP_A_LOCK &&
                         sst == lrotp_pkg::S_GOT1 &&
                         link.cmd_wdata[1:0] == `LROTP_RST_W2) begin
               sst <= lrotp_pkg::S_GOT2;
            end else if (wr && link.cmd_addr == `LROTP_A_LOCK &&
                         link.cmd_wdata[1:0] == `LROTP_RST_W1) begin
               sst <= lrotp_pkg::S_GOT1;
            end else begin
               sst <= lrotp_pkg::S_IDLE;
            end
         end
      end
   end
   // ==========================================
   // Program control register and sequencer
   always_ff @(posedge ref_clk) begin
      if (!nrst || device_reset) begin
         prog_reg <= `LROTP_REG_RST;
         pst      <= lrotp_pkg::P_IDLE;
         psel     <= 2'h0;
         pexl     <= 1'b0;
         pexp     <= 1'b0;
         pidx     <= 4'h0;
      end else begin
         case (pst)
            lrotp_pkg::P_IDLE: begin
               if (wr_free && link.cmd_addr == `LROTP_A_PROG) begin
                  prog_reg <= link.cmd_wdata;
                  // Reserved selector or locked region starts nothing
                  if (link.cmd_wdata[`LROTP_B_GO] &&
                      link.cmd_wdata[1:0] != `LROTP_RG_RSVD &&
                      !region_lock[link.cmd_wdata[1:0]]) begin
                     pst  <= lrotp_pkg::P_COPY;
                     psel <= link.cmd_wdata[1:0];
                     pexl <= link.cmd_wdata[`LROTP_B_EXLINK];
                     pexp <= link.cmd_wdata[`LROTP_B_EXPADDR];
                     pidx <= 4'h0;
                  end
               end
            end
            lrotp_pkg::P_COPY: begin
               pidx <= pidx + 4'h1;
               if (pidx == `LROTP_LAST_IDX) begin
                  pst <= lrotp_pkg::P_DONE;
               end
            end
            lrotp_pkg::P_DONE: begin
               pst <= lrotp_pkg::P_IDLE;
            end
            default: begin
               pst <= lrotp_pkg::P_IDLE;
            end
         endcase
      end
   end
   // CRC over the bytes actually programmed
   lrotp_crc8 u_crc (
      .ref_clk (ref_clk),
      .nrst    (nrst),
      .clear   (pst == lrotp_pkg::P_IDLE),
      .en      (pst == lrotp_pkg::P_COPY && !skip),
      .din     (src),
      .crc     (crc)
   );
   // ==========================================
   // Nonvolatile copies; only the sequencer writes them
   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         region_lock <= 3'h0;
         shr_owner   <= 2'h0;
         for (int r = 0; r < 3; r++) begin
            nv_crc[r] <= `LROTP_REG_RST;
            snap[r]   <= `LROTP_REG_RST;
            for (int i = 0; i < 16; i++) begin
               nv_mem[r][i] <= `LROTP_REG_RST;
            end
         end
      end else if (pst == lrotp_pkg::P_COPY && !skip) begin
         nv_mem[psel][pidx] <= src;
      end else if (pst == lrotp_pkg::P_DONE) begin
         nv_crc[psel]      <= crc;
         region_lock[psel] <= 1'b1;
         if (psel == `LROTP_RG_UF2) begin
            // The zeroed address byte sits six places rotated inside the fold
            snap[psel] <= fold(uf2_mirror, `LROTP_REG_RST) ^
                          (pexp ? {uf2_mirror[`LROTP_UF2_PADDR][1:0],
                                   uf2_mirror[`LROTP_UF2_PADDR][7:2]} : `LROTP_REG_RST);
         end else begin
            snap[psel] <= fold(shr_mirror, `LROTP_REG_RST);
            shr_owner  <= psel;
         end
      end
   end
   // ==========================================
   // Mirror registers
   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         for (int i = 0; i < 16; i++) begin
            shr_mirror[i] <= `LROTP_REG_RST;
            uf2_mirror[i] <= `LROTP_REG_RST;
         end
      end else begin
         if (wr_free && link.cmd_addr[7:4] == `LROTP_A_SHR) begin
            shr_mirror[link.cmd_addr[3:0]] <= link.cmd_wdata;
         end
         if (wr_free && link.cmd_addr[7:4] == `LROTP_A_UF2) begin
            uf2_mirror[link.cmd_addr[3:0]] <= link.cmd_wdata;
         end
         if (pst == lrotp_pkg::P_DONE && psel == `LROTP_RG_UF2 && pexp) begin
            uf2_mirror[`LROTP_UF2_PADDR] <= `LROTP_REG_RST;
         end
      end
   end
   // ==========================================
   // Register and region checks; a new error beats a clear
   always_ff @(posedge ref_clk) begin
      if (!nrst || device_reset) begin
         init_q             <= 1'b0;
         rw_ref             <= `LROTP_REG_RST;
         rw_check_error     <= 1'b0;
         region_check_error <= 1'b0;
      end else begin
         init_q <= init_lock;
         if (init_lock && !init_q) begin
            rw_ref <= sum_all;
         end
         if (init_q && sum_all != rw_ref) begin
            rw_check_error <= 1'b1;
         end else if (check_err_clear) begin
            rw_check_error <= 1'b0;
         end
         if ((region_lock[`LROTP_RG_UF2] &&
              fold(uf2_mirror, `LROTP_REG_RST) != snap[`LROTP_RG_UF2]) ||
             (region_lock[shr_owner] && shr_owner != `LROTP_RG_UF2 &&
              fold(shr_mirror, `LROTP_REG_RST) != snap[shr_owner])) begin
            region_check_error <= 1'b1;
         end else if (check_err_clear) begin
            region_check_error <= 1'b0;
         end
      end
   end
   // ==========================================
   // Answers: two cycles after the command is taken
   always_ff @(posedge ref_clk) begin
      if (!nrst || device_reset) begin
         rsp_pend       <= 1'b0;
         rsp_wr         <= 1'b0;
         rsp_addr       <= `LROTP_REG_RST;
         link.rsp_valid <= 1'b0;
         link.rsp_data  <= `LROTP_REG_RST;
      end else begin
         rsp_pend       <= take & access_ok & ~(mode_dsi3 & init_lock);
         rsp_wr         <= link.cmd_write;
         rsp_addr       <= link.cmd_addr;
         link.rsp_valid <= rsp_pend;
         case (rsp_addr[7:4])
            `LROTP_A_SHR: link.rsp_data <= shr_mirror[rsp_addr[3:0]];
            `LROTP_A_UF2: link.rsp_data <= uf2_mirror[rsp_addr[3:0]];
            default: begin
               case (rsp_addr)
                  `LROTP_A_REV:  link.rsp_data <= rsp_wr ? `LROTP_REG_RST
                                                          : {4'h0, REV_CODE};
                  `LROTP_A_TEMP: link.rsp_data <= temp_reg;
                  `LROTP_A_LOCK: link.rsp_data <= lock_reg;
                  `LROTP_A_PROG: link.rsp_data <= prog_reg;
                  default:       link.rsp_data <= `LROTP_REG_RST;
               endcase
            end
         endcase
      end
   end
   // ==========================================
   // Status outputs
   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         p0_filter_final             <= 1'b0;
         self_test_inhibit           <= 1'b0;
         force_pdcm                  <= 1'b0;
         supply_error_report_disable <= 1'b0;
         programming_active          <= 1'b0;
      end else begin
         p0_filter_final             <= init_lock;
         self_test_inhibit           <= init_lock;
         force_pdcm                  <= init_lock & mode_dsi3;
         supply_error_report_disable <= lock_reg[`LROTP_B_SUPDIS];
         programming_active          <= (pst != lrotp_pkg::P_IDLE);
      end
   end
endmodule

// ==== design/lrotp_host.sv ====
/*
 Bus master end: Wishbone classic slave taking one command word from
 software, sending it on the link and reporting the answer.
 Assumes the same clock as the device end.
*/
`timescale 1ns/10ps
`include "lrotp_cfg.svh"
module lrotp_host #(
   parameter int RESP_CYCLES = `LROTP_T_RESP_NS / `LROTP_CLK_NS
) (
   input  wire logic        ref_clk,
   input  wire logic        nrst,
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [7:0]  wb_adr_i,
   input  wire logic [31:0] wb_dat_i,
   input  wire logic [3:0]  wb_sel_i,
   output logic      [31:0] wb_dat_o,
   output logic             wb_ack_o,
   lrotp_if.host            link
);
   // ==========================================
   // State
   lrotp_pkg::lrotp_host_t hst;  // Link state
   logic [7:0]  rsp_byte;        // Last answer
   logic        no_answer;       // Last command timed out
   logic [15:0] wait_cnt;        // Answer timeout count
   logic        req;             // Live bus request
   assign req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   // ==========================================
   // Bus answer, one cycle after the request
   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
      end else begin
         wb_ack_o <= req;
         if (req && !wb_we_i && wb_adr_i == `LROTP_WB_STAT) begin
            wb_dat_o <= {16'h0000, rsp_byte, 6'h00, no_answer, hst == lrotp_pkg::H_WAIT};
         end else begin
            wb_dat_o <= 32'h0000_0000;
         end
      end
   end
   // ==========================================
   // One link command per software write to the command word with wb_sel_i bits 2:0 set while idle, never interleaved
   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         hst            <= lrotp_pkg::H_IDLE;
         link.cmd_valid <= 1'b0;
         link.cmd_write <= 1'b0;
         link.cmd_addr  <= 8'h00;
         link.cmd_wdata <= 8'h00;
         rsp_byte       <= 8'h00;
         no_answer      <= 1'b0;
         wait_cnt       <= 16'h0000;
      end else begin
         link.cmd_valid <= 1'b0;
         case (hst)
            lrotp_pkg::H_IDLE: begin
               if (req && wb_we_i && wb_adr_i == `LROTP_WB_CMD && wb_sel_i[2:0] == 3'h7) begin
                  link.cmd_valid <= 1'b1;
                  link.cmd_wdata <= wb_dat_i[7:0];
                  link.cmd_addr  <= wb_dat_i[15:8];
                  link.cmd_write <= wb_dat_i[16];
                  no_answer      <= 1'b0;
                  wait_cnt       <= 16'h0000;
                  hst            <= lrotp_pkg::H_WAIT;
               end
            end
            lrotp_pkg::H_WAIT: begin
               wait_cnt <= wait_cnt + 16'h0001;
               if (link.rsp_valid) begin
                  rsp_byte <= link.rsp_data;
                  hst      <= lrotp_pkg::H_IDLE;
               end else if (wait_cnt == 16'(RESP_CYCLES - 1)) begin
                  no_answer <= 1'b1;
                  hst       <= lrotp_pkg::H_IDLE;
               end
            end
            default: begin
               hst <= lrotp_pkg::H_IDLE;
            end
         endcase
      end
   end
endmodule

// ==== test/lrotp_props.sv ====
/* Link checker for the lock, reset and OTP register bank.
   Assumes one clock and a synchronous active-low reset. */
`timescale 1ns/10ps
module lrotp_props (
   input wire logic       ref_clk,
   input wire logic       nrst,
   input wire logic       cmd_valid,
   input wire logic       cmd_write,
   input wire logic [7:0] cmd_addr,
   input wire logic [7:0] cmd_wdata,
   input wire logic       rsp_valid,
   input wire logic [7:0] rsp_data
);
   // ==========================================
   // Strobe timing on the link
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!nrst);
   property p_cmd1; cmd_valid |=> !cmd_valid; endproperty
   property p_rsp1; rsp_valid |=> !rsp_valid; endproperty
   property p_rsp2; rsp_valid |-> $past(cmd_valid, 2); endproperty
   property p_hold; !cmd_valid |-> $stable(cmd_addr) && $stable(cmd_wdata); endproperty
   a_cmd1: assert property (p_cmd1) else $error("command strobe too long");
   a_rsp1: assert property (p_rsp1) else $error("answer strobe too long");
   a_rsp2: assert property (p_rsp2) else $error("answer without command");
   a_hold: assert property (p_hold) else $error("command fields moved");
   // ==========================================
   // Answer contents tied to the command
   sequence s_ans(a, w, b);
      cmd_valid && cmd_write == w && cmd_addr == a && (cmd_wdata[7] || !b) ##2 rsp_valid;
   endsequence
   property p_rev_rd; s_ans(8'h05, 1'b0, 1'b0) |-> rsp_data[7:4] == 4'h0; endproperty
   property p_rev_wr; s_ans(8'h05, 1'b1, 1'b0) |-> rsp_data == 8'h00; endproperty
   property p_init; s_ans(8'h10, 1'b1, 1'b1) |-> rsp_data[7]; endproperty
   property p_go; s_ans(8'h11, 1'b1, 1'b1) |-> rsp_data[7]; endproperty
   a_rev_rd: assert property (p_rev_rd) else $error("revision upper bits set");
   a_rev_wr: assert property (p_rev_wr) else $error("revision write answer not zero");
   a_init: assert property (p_init) else $error("init lock bit not held");
   a_go: assert property (p_go) else $error("initiate bit not held");
   c_rev_wr: cover property (s_ans(8'h05, 1'b1, 1'b0));
   c_init: cover property (s_ans(8'h10, 1'b1, 1'b1));
   c_go: cover property (s_ans(8'h11, 1'b1, 1'b1));
endmodule

// ==== test/lrotp_tb.sv ====
/* Bench: host and device joined on the link, driven over Wishbone.
   Assumes the design files under design/. */
`timescale 1ns/10ps
module lock_reset_and_user_otp_programming_tb;
   logic ref_clk = 0, nrst = 0, cyc = 0, stb = 0, we = 0, md = 1, pd = 0, tv = 0, x3 = 0;
   logic [7:0]  adr = '0, tval = '0, ans;
   logic [31:0] wdat = '0, rdat, dout;
   logic [3:0]  sel = '0;
   logic        ack, dres, filt, sti, pdcm, sup, nans, rwe, rce, pact;
   logic [2:0]  lock;
   int          n_mismatch = 0, checks = 0, n_rst = 0;
   lrotp_if lk ();
   lrotp_host #(.RESP_CYCLES(50)) u_lrotp_host (.ref_clk, .nrst, .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(sel), .wb_dat_o(dout),
      .wb_ack_o(ack), .link(lk));
   lrotp_device u_lrotp_device (.ref_clk, .nrst, .link(lk), .mode_dsi3(md), .mode_psi5_diag(pd),
      .psi5_init3_exit(x3), .temp_value(tval), .temp_valid(tv), .check_err_clear(1'b0),
      .device_reset(dres), .p0_filter_final(filt), .self_test_inhibit(sti), .force_pdcm(pdcm),
      .supply_error_report_disable(sup), .rw_check_error(rwe), .region_check_error(rce),
      .programming_active(pact), .region_lock(lock));
   lrotp_props u_lrotp_props (.ref_clk, .nrst, .cmd_valid(lk.cmd_valid), .cmd_write(lk.cmd_write),
      .cmd_addr(lk.cmd_addr), .cmd_wdata(lk.cmd_wdata), .rsp_valid(lk.rsp_valid),
      .rsp_data(lk.rsp_data));
   always #25 ref_clk = ~ref_clk;
   // Count reset pulses from the device
   always @(posedge ref_clk) begin
      if (dres === 1'b1) n_rst <= n_rst + 1;
   end
   task automatic stop_test;
      $display("checks %0d mismatches %0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("mismatch at %0t: got %h exp %h", $time, got, exp);
      end
   endtask
   // One classic Wishbone cycle, held until ack is sampled
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      {cyc, stb, we, adr, wdat, sel} <= {1'b1, 1'b1, w, a, d, 4'hf};
      // The wait ends when ack is seen; only the watchdog ends a wait for an ack that never comes
      do @(posedge ref_clk); while (ack !== 1'b1);
      rdat = dout;
      {cyc, stb} <= 2'h0;
   endtask
   // Link command, then poll status until the answer or no-answer
   task automatic cmd(input logic w, input logic [7:0] a, input logic [7:0] d);
      wb(1'b1, 8'h00, {15'h0000, w, a, d});
      do wb(1'b0, 8'h04, 32'h0000_0000); while (rdat[0] !== 1'b0);
      ans = rdat[15:8];
      nans = rdat[1];
   endtask
   initial begin
      #1000000;
      n_mismatch++;
      stop_test;
   end
   initial begin
      repeat (5) @(posedge ref_clk);
      nrst <= 1;
      cmd(1'b0, 8'h05, 8'h00); chk(ans, 8'h09);
      cmd(1'b1, 8'h05, 8'h3c); chk(ans, 8'h00);
      {tval, tv} <= {8'h5a, 1'b1};
      @(posedge ref_clk) tv <= 1'b0;
      cmd(1'b0, 8'h0e, 8'h00); chk(ans, 8'h5a);
      cmd(1'b1, 8'h10, 8'h08); chk({7'h00, sup}, 8'h01);
      cmd(1'b1, 8'h10, 8'h00); cmd(1'b1, 8'h10, 8'h01); cmd(1'b1, 8'h10, 8'h00);
      cmd(1'b0, 8'h05, 8'h00); cmd(1'b1, 8'h10, 8'h03); cmd(1'b1, 8'h10, 8'h01);
      chk(n_rst[7:0], 8'h00);
      cmd(1'b1, 8'h10, 8'h00); cmd(1'b1, 8'h10, 8'h03); cmd(1'b1, 8'h10, 8'h01);
      chk(n_rst[7:0], 8'h01);
      cmd(1'b0, 8'h10, 8'h00); chk(ans, 8'h00);
      cmd(1'b1, 8'h20, 8'ha5); chk(ans, 8'ha5);
      cmd(1'b1, 8'h11, 8'h83); repeat (30) @(posedge ref_clk); chk({5'h00, lock}, 8'h00);
      cmd(1'b1, 8'h11, 8'h80); chk({7'h00, pact}, 8'h01);
      repeat (30) @(posedge ref_clk); chk({5'h00, lock}, 8'h01);
      cmd(1'b1, 8'h31, 8'h7e); cmd(1'b1, 8'h11, 8'h86);
      repeat (30) @(posedge ref_clk); chk({5'h00, lock}, 8'h05);
      cmd(1'b0, 8'h31, 8'h00); chk(ans, 8'h00); chk({7'h00, rce}, 8'h00);
      cmd(1'b1, 8'h31, 8'h44); chk(ans, 8'h44); chk({7'h00, rce}, 8'h01);
      cmd(1'b1, 8'h10, 8'h80); chk({5'h00, filt, sti, pdcm}, 8'h07);
      cmd(1'b0, 8'h10, 8'h00); chk({7'h00, nans}, 8'h01);
      {md, pd} <= 2'h1;
      cmd(1'b1, 8'h10, 8'h00); chk(ans, 8'h80);
      cmd(1'b1, 8'h11, 8'h01); chk(ans, 8'h86); chk({7'h00, rwe}, 8'h00);
      pd <= 1'b0;
      cmd(1'b0, 8'h11, 8'h00); chk({7'h00, nans}, 8'h01);
      pd <= 1'b1;
      cmd(1'b1, 8'h10, 8'h00); cmd(1'b1, 8'h10, 8'h03); cmd(1'b1, 8'h10, 8'h01);
      cmd(1'b0, 8'h10, 8'h00); chk(ans, 8'h00); chk(n_rst[7:0], 8'h02);
      x3 <= 1'b1;
      @(posedge ref_clk) x3 <= 1'b0;
      cmd(1'b0, 8'h10, 8'h00); chk(ans, 8'h80);
      stop_test;
   end
endmodule
